// ### core/cpd_core.sv
`timescale 1ns/1ns
// Overview of operation
// [R1] broker cycles endlessly through all mapping entries
// [R2] producer input words copied to consumer output
// [R3] host reads input areas at any time
// [R4] input area written only by owning channel
// [R5] input words read zero until first written
// [R6] unwritten output words stay zero, no drop-off
// [R7] output areas written only by the broker
// [R8] host reads of output areas are refused
// [R9] eight entries per consumer, packed in order
// [R10] entry is base register, count with swap
// [R11] invalid entry raises the mapping error flag
// [R12] coils address single bits of same words
// [R13] areas restart from zero after every reset

module cpd_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16
) (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // filling side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // draining side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
   } cpd_fifo_s;
   cpd_fifo_s q_r, q_nxt;
   logic [WIDTH-1:0] mem [DEPTH];
   logic full, empty, push, pop;

   assign full = (q_r.wp[AW-1:0] == q_r.rp[AW-1:0]) && (q_r.wp[AW] != q_r.rp[AW]);
   assign empty = (q_r.wp == q_r.rp);
   assign push = in_valid_i && !full;
   assign pop = out_ready_i && !empty;
   assign in_ready_o = !full;
   assign out_valid_o = !empty;
   assign out_data_o = mem[q_r.rp[AW-1:0]];

   always_comb begin
      q_nxt = q_r;
      if (push) begin
         q_nxt.wp = q_r.wp + 1'b1;
      end
      if (pop) begin
         q_nxt.rp = q_r.rp + 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   // payload storage needs no reset, only the pointers say what is valid
   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem[q_r.wp[AW-1:0]] <= in_data_i;
      end
   end
endmodule

module cpd_core (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // host serial channel register access
   input wire logic host_req_i,
   input wire logic host_wr_i,
   input wire logic host_coil_i,
   input wire logic [15:0] host_addr_i,
   input wire logic [15:0] host_wdata_i,
   output logic host_ack_o,
   output logic host_err_o,
   output logic [15:0] host_rdata_o,
   // shift chain channel input writes
   input wire logic shift_chain_channel_wr_i,
   input wire logic [6:0] shift_chain_channel_idx_i,
   input wire logic [15:0] shift_chain_channel_data_i,
   // fieldbus channel input writes
   input wire logic fb_channel_wr_i,
   input wire logic [6:0] fb_channel_idx_i,
   input wire logic [15:0] fb_channel_data_i,
   // consumer reads of output areas
   input wire logic out_rd_i,
   input wire logic out_area_i,
   input wire logic [6:0] out_idx_i,
   output logic [15:0] out_rdata_o,
   // mapping entries per consumer
   input wire logic [15:0] map_base_i [cpd_pkg::OUT_AREAS][cpd_pkg::MAP_ENTRIES],
   input wire logic [15:0] map_cnt_i [cpd_pkg::OUT_AREAS][cpd_pkg::MAP_ENTRIES],
   // status
   output logic map_err_o
);
   // ***************************************************************
   // decoding
   // ***************************************************************
   // returns {hit, area, word index}
   function automatic logic [9:0] dec_reg(input logic [15:0] a);
      logic [15:0] o0, o1, o2;
      o0 = a - cpd_pkg::REG_SHIFT_IN;
      o1 = a - cpd_pkg::REG_HOST_IN;
      o2 = a - cpd_pkg::REG_FB_IN;
      if (o0 < cpd_pkg::AREA_WORDS_W) begin
         dec_reg = {1'b1, cpd_pkg::AREA_SHIFT, o0[6:0]};
      end else if (o1 < cpd_pkg::AREA_WORDS_W) begin
         dec_reg = {1'b1, cpd_pkg::AREA_HOST, o1[6:0]};
      end else if (o2 < cpd_pkg::AREA_WORDS_W) begin
         dec_reg = {1'b1, cpd_pkg::AREA_FB, o2[6:0]};
      end else begin
         dec_reg = '0;
      end
   endfunction

   // returns {hit, area, word index, bit}
   function automatic logic [13:0] dec_coil(input logic [15:0] a);
      logic [15:0] o0, o1, o2;
      o0 = a - cpd_pkg::COIL_SHIFT_IN;
      o1 = a - cpd_pkg::COIL_HOST_IN;
      o2 = a - cpd_pkg::COIL_FB_IN;
      if (o0 < cpd_pkg::AREA_COILS_W) begin
         dec_coil = {1'b1, cpd_pkg::AREA_SHIFT, o0[10:0]};
      end else if (o1 < cpd_pkg::AREA_COILS_W) begin
         dec_coil = {1'b1, cpd_pkg::AREA_HOST, o1[10:0]};
      end else if (o2 < cpd_pkg::AREA_COILS_W) begin
         dec_coil = {1'b1, cpd_pkg::AREA_FB, o2[10:0]};
      end else begin
         dec_coil = '0;
      end
   endfunction

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      cpd_pkg::cpd_state_e st;
      logic cons;
      logic [2:0] ent;
      logic [15:0] left;
      logic [1:0] src_area;
      logic [6:0] src_idx;
      logic [7:0] dst;
      logic swap;
      logic err_acc;
      logic map_err;
      logic ack;
      logic err;
      logic [15:0] rdata;
      logic [15:0] out_rdata;
   } cpd_core_s;
   cpd_core_s s_r, s_nxt;

   logic [15:0] in_mem [cpd_pkg::IN_AREAS][cpd_pkg::AREA_WORDS];
   logic [15:0] out_mem [cpd_pkg::OUT_AREAS][cpd_pkg::AREA_WORDS];

   logic [9:0] hreg;
   logic [13:0] hcoil;
   logic host_we;
   logic [6:0] host_widx;
   logic [15:0] host_wword;
   logic [15:0] cur_word;
   logic [9:0] sdec;
   logic [15:0] src_word;
   logic adv;
   logic push;
   logic [cpd_pkg::FIFO_W-1:0] push_data;
   logic push_ready;
   logic drain_valid;
   logic drain_ready;
   logic [cpd_pkg::FIFO_W-1:0] drain_data;

   assign hreg = dec_reg(host_addr_i);
   assign hcoil = dec_coil(host_addr_i);
   assign sdec = dec_reg(map_base_i[s_r.cons][s_r.ent]);
   assign src_word = in_mem[s_r.src_area][s_r.src_idx];

   // ***************************************************************
   // host access
   // ***************************************************************
   always_comb begin
      host_we = 1'b0;
      host_widx = hcoil[10:4];
      cur_word = in_mem[cpd_pkg::AREA_HOST][hcoil[10:4]];
      host_wword = cur_word;
      if (host_req_i && host_wr_i) begin
         if (host_coil_i) begin
            host_we = hcoil[13] && (hcoil[12:11] == cpd_pkg::AREA_HOST); // [R4] [R7]
            host_wword[hcoil[3:0]] = host_wdata_i[0]; // [R12]
         end else begin
            host_we = hreg[9] && (hreg[8:7] == cpd_pkg::AREA_HOST); // [R4] [R7]
            host_widx = hreg[6:0];
            host_wword = host_wdata_i;
         end
      end
   end

   // ***************************************************************
   // broker and registered answers
   // ***************************************************************
   always_comb begin
      s_nxt = s_r;
      adv = 1'b0;
      push = 1'b0;
      push_data = {s_r.cons, s_r.dst[6:0], src_word};
      if (s_r.swap) begin
         push_data = {s_r.cons, s_r.dst[6:0], src_word[7:0], src_word[15:8]}; // [R10]
      end
      s_nxt.ack = host_req_i;
      s_nxt.err = 1'b0;
      s_nxt.rdata = cpd_pkg::WORD_ZERO;
      if (host_req_i) begin
         if (host_wr_i) begin
            s_nxt.err = !host_we; // [R4] [R7]
         end else if (host_coil_i) begin
            s_nxt.err = !hcoil[13]; // [R8]
            if (hcoil[13]) begin
               s_nxt.rdata = {15'h0000, in_mem[hcoil[12:11]][hcoil[10:4]][hcoil[3:0]]}; // [R12]
            end
         end else begin
            s_nxt.err = !hreg[9]; // [R8]
            if (hreg[9]) begin
               s_nxt.rdata = in_mem[hreg[8:7]][hreg[6:0]]; // [R3]
            end
         end
      end
      s_nxt.out_rdata = out_rd_i ? out_mem[out_area_i][out_idx_i] : s_r.out_rdata;
      case (s_r.st)
         cpd_pkg::CPD_SCAN: begin
            // zero count marks an unused entry
            if (map_cnt_i[s_r.cons][s_r.ent][cpd_pkg::CNT_MSB:0] == 15'h0000) begin
               adv = 1'b1;
            end else if (!sdec[9]
                  || ({9'h000, sdec[6:0]} + {1'b0, map_cnt_i[s_r.cons][s_r.ent][14:0]})
                     > cpd_pkg::AREA_WORDS_W
                  || ({8'h00, s_r.dst} + {1'b0, map_cnt_i[s_r.cons][s_r.ent][14:0]})
                     > cpd_pkg::AREA_WORDS_W) begin
               s_nxt.err_acc = 1'b1; // [R11]
               adv = 1'b1;
            end else begin
               s_nxt.left = {1'b0, map_cnt_i[s_r.cons][s_r.ent][cpd_pkg::CNT_MSB:0]}; // [R10]
               s_nxt.swap = map_cnt_i[s_r.cons][s_r.ent][cpd_pkg::CNT_SWAP_BIT]; // [R10]
               s_nxt.src_area = sdec[8:7];
               s_nxt.src_idx = sdec[6:0];
               s_nxt.st = cpd_pkg::CPD_COPY;
            end
         end
         cpd_pkg::CPD_COPY: begin
            push = 1'b1; // [R2]
            if (push_ready) begin
               s_nxt.src_idx = s_r.src_idx + 7'h01;
               s_nxt.dst = s_r.dst + 8'h01; // [R9]
               s_nxt.left = s_r.left - 16'h0001;
               if (s_r.left == 16'h0001) begin
                  s_nxt.st = cpd_pkg::CPD_SCAN;
                  adv = 1'b1;
               end
            end
         end
         default: begin
            s_nxt.st = cpd_pkg::CPD_SCAN;
         end
      endcase
      if (adv) begin
         s_nxt.ent = s_r.ent + 3'h1; // [R9]
         if (s_r.ent == 3'(cpd_pkg::MAP_ENTRIES - 1)) begin
            s_nxt.cons = !s_r.cons;
            s_nxt.dst = 8'h00;
            // flag reflects the whole pass, so a fixed table clears it
            if (s_r.cons) begin
               s_nxt.map_err = s_nxt.err_acc; // [R11]
               s_nxt.err_acc = 1'b0; // [R1]
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ***************************************************************
   // broker payload fifo
   // ***************************************************************
   // consumer reads own the output port, so broker writes wait behind them
   assign drain_ready = !out_rd_i;

   cpd_fifo #(
      .WIDTH(cpd_pkg::FIFO_W),
      .DEPTH(cpd_pkg::FIFO_D)
   ) u_fifo (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .in_valid_i(push),
      .in_ready_o(push_ready),
      .in_data_i(push_data),
      .out_valid_o(drain_valid),
      .out_ready_i(drain_ready),
      .out_data_o(drain_data)
   );

   // ***************************************************************
   // storage
   // ***************************************************************
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         in_mem <= '{default: cpd_pkg::WORD_ZERO}; // [R5] [R13]
      end else begin
         if (shift_chain_channel_wr_i) begin
            in_mem[cpd_pkg::AREA_SHIFT][shift_chain_channel_idx_i] <=
               shift_chain_channel_data_i; // [R4]
         end
         if (fb_channel_wr_i) begin
            in_mem[cpd_pkg::AREA_FB][fb_channel_idx_i] <= fb_channel_data_i; // [R4]
         end
         if (host_we) begin
            in_mem[cpd_pkg::AREA_HOST][host_widx] <= host_wword; // [R4]
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         out_mem <= '{default: cpd_pkg::WORD_ZERO}; // [R6] [R13]
      end else if (drain_valid && drain_ready) begin
         out_mem[drain_data[23]][drain_data[22:16]] <= drain_data[15:0]; // [R7]
      end
   end

   assign host_ack_o = s_r.ack;
   assign host_err_o = s_r.err;
   assign host_rdata_o = s_r.rdata;
   assign out_rdata_o = s_r.out_rdata;
   assign map_err_o = s_r.map_err;
endmodule

// ### core/cpd_pkg.sv
package cpd_pkg;
   // ***************************************************************
   // geometry of the channel data areas
   // ***************************************************************
   localparam int AREA_WORDS = 128;
   localparam int IN_AREAS = 3;
   localparam int OUT_AREAS = 2;
   localparam int MAP_ENTRIES = 8;
   localparam logic [15:0] AREA_WORDS_W = 16'h0080;
   localparam logic [15:0] AREA_COILS_W = 16'h0800;
   localparam logic [15:0] WORD_ZERO = 16'h0000;

   // ***************************************************************
   // register numbers and coil addresses
   // ***************************************************************
   localparam logic [15:0] REG_SHIFT_IN = 16'h1001;
   localparam logic [15:0] REG_HOST_IN = 16'h1401;
   localparam logic [15:0] REG_FB_IN = 16'h1801;
   localparam logic [15:0] REG_OUT0 = 16'h2001;
   localparam logic [15:0] REG_OUT1 = 16'h2401;
   localparam logic [15:0] COIL_SHIFT_IN = 16'h0001;
   localparam logic [15:0] COIL_HOST_IN = 16'h2001;
   localparam logic [15:0] COIL_FB_IN = 16'h4001;

   // ***************************************************************
   // mapping entry fields
   // ***************************************************************
   localparam int CNT_SWAP_BIT = 15;
   localparam int CNT_MSB = 14;

   // ***************************************************************
   // area codes and broker payload
   // ***************************************************************
   localparam logic [1:0] AREA_SHIFT = 2'h0;
   localparam logic [1:0] AREA_HOST = 2'h1;
   localparam logic [1:0] AREA_FB = 2'h2;
   localparam int FIFO_W = 24;
   localparam int FIFO_D = 16;

   typedef enum logic [0:0] {
      CPD_SCAN,
      CPD_COPY
   } cpd_state_e;
endpackage

// ### tb/cpd_core_checker.sv
`timescale 1ns/1ns
module cpd_core_checker (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // host access
   input wire logic host_req_i,
   input wire logic host_wr_i,
   input wire logic host_coil_i,
   input wire logic [15:0] host_addr_i,
   input wire logic host_ack_o,
   input wire logic host_err_o,
   input wire logic [15:0] host_rdata_o,
   // consumer reads
   input wire logic out_rd_i,
   input wire logic [15:0] out_rdata_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   logic rq;
   assign rq = host_req_i && !host_coil_i;
   a_ack_follows_req: assert property (host_req_i |=> host_ack_o)
      else $error("no answer to host request");
   a_ack_not_alone: assert property (!host_req_i |=> !host_ack_o)
      else $error("answer without request");
   a_err_with_ack: assert property (host_err_o |-> host_ack_o)
      else $error("refusal without answer");
   a_out_wr_refused: assert property (rq && host_wr_i && host_addr_i[15:12] == 4'h2
      |=> host_err_o)
      else $error("output area write taken");
   a_out_rd_refused: assert property (rq && !host_wr_i && host_addr_i[15:12] == 4'h2
      |=> host_err_o && host_rdata_o == 16'h0000)
      else $error("output area read answered");
   a_shift_wr_refused: assert property (rq && host_wr_i
      && host_addr_i inside {[16'h1001:16'h1080]} |=> host_err_o)
      else $error("shift chain area written by host");
   a_host_wr_taken: assert property (rq && host_wr_i
      && host_addr_i inside {[16'h1401:16'h1480]} |=> !host_err_o)
      else $error("host area write refused");
   a_in_rd_taken: assert property (rq && !host_wr_i
      && host_addr_i inside {[16'h1001:16'h1080], [16'h1801:16'h1880]} |=> !host_err_o)
      else $error("input area read refused");
   a_out_data_holds: assert property (!out_rd_i |=> $stable(out_rdata_o))
      else $error("output read data moved without strobe");
   c_host_write: cover property (rq && host_wr_i);
   c_coil_access: cover property (host_req_i && host_coil_i);
   c_refusal: cover property (host_err_o);
   c_out_data: cover property (out_rd_i ##1 out_rdata_o != 16'h0000);
endmodule
bind cpd_core cpd_core_checker i_chk (.sys_clk_i, .rst_b_i, .host_req_i, .host_wr_i,
   .host_coil_i, .host_addr_i, .host_ack_o, .host_err_o, .host_rdata_o, .out_rd_i,
   .out_rdata_o);

// ### tb/cpd_host_model.sv
`timescale 1ns/1ns
module cpd_host_model (
   // clock
   input wire logic sys_clk_i,
   // request side
   output logic host_req_o,
   output logic host_wr_o,
   output logic host_coil_o,
   output logic [15:0] host_addr_o,
   output logic [15:0] host_wdata_o,
   // answer side
   input wire logic host_ack_i,
   input wire logic host_err_i,
   input wire logic [15:0] host_rdata_i
);
   initial begin
      host_req_o = 1'b0;
      host_wr_o = 1'b0;
      host_coil_o = 1'b0;
      host_addr_o = 16'h0000;
      host_wdata_o = 16'h0000;
   end
   // one request pulse, answer taken at the next rising edge
   task automatic access(input logic wr, input logic coil, input logic [15:0] addr,
      input logic [15:0] wd, output logic [15:0] rd, output logic err, output logic ack);
      @(posedge sys_clk_i);
      host_req_o <= 1'b1;
      host_wr_o <= wr;
      host_coil_o <= coil;
      host_addr_o <= addr;
      host_wdata_o <= wd;
      @(posedge sys_clk_i);
      host_req_o <= 1'b0;
      // stale write data is inverted so nothing relies on it lingering
      host_wdata_o <= ~wd;
      // answer stands for exactly one cycle, so it is taken at the edge that closes it
      @(posedge sys_clk_i);
      ack = host_ack_i;
      rd = host_rdata_i;
      err = host_err_i;
   endtask
endmodule

// ### tb/test_channel_process_data_memory.sv
`timescale 1ns/1ns
module test_channel_process_data_memory;
   logic clk = 1'b0, rst_b = 1'b0, req, wr, coil, ack, err, sw = 0, fw = 0, ord = 0, oa = 0;
   logic merr;
   logic [6:0] si = 0, fi = 0, oi = 0;
   logic [15:0] addr, wd, rd, sd = 0, fd = 0, od;
   logic [15:0] mb [2][8], mc [2][8];
   int fail_count = 0, n_checks = 0, cyc = 0;
   always #50 clk = ~clk;
   cpd_host_model i_host (.sys_clk_i(clk), .host_req_o(req), .host_wr_o(wr),
      .host_coil_o(coil), .host_addr_o(addr), .host_wdata_o(wd), .host_ack_i(ack),
      .host_err_i(err), .host_rdata_i(rd));
   cpd_core i_dut (.sys_clk_i(clk), .rst_b_i(rst_b), .host_req_i(req), .host_wr_i(wr),
      .host_coil_i(coil), .host_addr_i(addr), .host_wdata_i(wd), .host_ack_o(ack),
      .host_err_o(err), .host_rdata_o(rd), .shift_chain_channel_wr_i(sw),
      .shift_chain_channel_idx_i(si), .shift_chain_channel_data_i(sd),
      .fb_channel_wr_i(fw), .fb_channel_idx_i(fi), .fb_channel_data_i(fd),
      .out_rd_i(ord), .out_area_i(oa), .out_idx_i(oi), .out_rdata_o(od),
      .map_base_i(mb), .map_cnt_i(mc), .map_err_o(merr));
   task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic hacc(logic w, logic c, logic [15:0] a, logic [15:0] d,
      logic [15:0] exp, logic e);
      logic [15:0] r;
      logic ef;
      logic af;
      i_host.access(w, c, a, d, r, ef, af);
      check("host ack", {15'h0000, af}, 16'h0001);
      check("host err", {15'h0000, ef}, {15'h0000, e});
      check("host rdata", r, exp);
   endtask
   task automatic oread(logic a, logic [6:0] i, logic [15:0] exp);
      @(posedge clk);
      ord <= 1'b1;
      oa <= a;
      oi <= i;
      @(posedge clk);
      ord <= 1'b0;
      @(negedge clk);
      check("out word", od, exp);
   endtask
   task automatic chw(logic f, logic [6:0] i, logic [15:0] d);
      @(posedge clk);
      sw <= !f;
      si <= i;
      sd <= d;
      fw <= f;
      fi <= i;
      fd <= d;
      @(posedge clk);
      sw <= 1'b0;
      fw <= 1'b0;
   endtask
   task automatic wait_cyc(int n);
      repeat (n) @(posedge clk);
   endtask
   // hang guard, well above the roughly 480 cycles the tests need
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         fail_count++;
         wrap_up();
      end
   end
   initial begin
      foreach (mb[c, e]) begin
         mb[c][e] = 16'h0000;
         mc[c][e] = 16'h0000;
      end
      wait_cyc(10);
      rst_b <= 1'b1;
      hacc(0, 0, 16'h1001, 0, 0, 0);
      hacc(0, 0, 16'h1480, 0, 0, 0);
      hacc(0, 0, 16'h1880, 0, 0, 0);
      hacc(0, 1, 16'h4800, 0, 0, 0);
      $display("test reset_zero done");
      hacc(1, 0, 16'h1401, 16'h1234, 0, 0);
      hacc(0, 1, 16'h2001, 0, 16'h0000, 0);
      hacc(0, 1, 16'h2005, 0, 16'h0001, 0);
      hacc(1, 1, 16'h2001, 16'h0001, 0, 0);
      hacc(0, 0, 16'h1401, 0, 16'h1235, 0);
      hacc(1, 0, 16'h1001, 16'h5555, 0, 1);
      hacc(1, 1, 16'h0001, 16'h0001, 0, 1);
      hacc(0, 0, 16'h1001, 0, 0, 0);
      hacc(0, 1, 16'h8001, 0, 0, 1);
      $display("test host_area done");
      chw(0, 0, 16'ha5b6);
      chw(0, 1, 16'h0102);
      chw(1, 0, 16'h7788);
      hacc(0, 0, 16'h1002, 0, 16'h0102, 0);
      hacc(0, 1, 16'h4004, 0, 16'h0001, 0);
      hacc(0, 1, 16'h0002, 0, 16'h0001, 0);
      $display("test channel_write done");
      @(posedge clk);
      mb[0][0] <= 16'h1001;
      mc[0][0] <= 16'h0002;
      mb[0][1] <= 16'h1801;
      mc[0][1] <= 16'h8001;
      mb[1][0] <= 16'h1401;
      mc[1][0] <= 16'h0001;
      // strobe held high stalls the drain so words queue in the buffer, which stays short of full, so the broker never waits
      ord <= 1'b1;
      wait_cyc(60);
      ord <= 1'b0;
      wait_cyc(100);
      oread(0, 0, 16'ha5b6);
      oread(0, 1, 16'h0102);
      oread(0, 2, 16'h8877);
      oread(0, 3, 16'h0000);
      oread(1, 0, 16'h1235);
      check("map err", {15'h0000, merr}, 16'h0000);
      hacc(0, 0, 16'h2001, 0, 0, 1);
      hacc(1, 0, 16'h2401, 16'h9999, 0, 1);
      oread(1, 0, 16'h1235);
      $display("test broker done");
      chw(0, 0, 16'h1111);
      @(posedge clk);
      mb[1][1] <= 16'h3000;
      mc[1][1] <= 16'h0001;
      wait_cyc(120);
      oread(0, 0, 16'h1111);
      check("map err", {15'h0000, merr}, 16'h0001);
      $display("test invalid_entry done");
      @(posedge clk);
      rst_b <= 1'b0;
      wait_cyc(2);
      rst_b <= 1'b1;
      hacc(0, 0, 16'h1401, 0, 0, 0);
      wait_cyc(100);
      oread(0, 0, 16'h0000);
      check("map err", {15'h0000, merr}, 16'h0001);
      $display("test second_reset done");
      wrap_up();
   end
endmodule
